/* File: pkg/vim_pkg.sv */
// vim_pkg: widths, register map, row layout and source classes of the signal matrix
// assumes: word-addressed register port with 10-bit address and 32-bit data
package vim_pkg;

  // signal counts
  localparam int SRC_W = 96;
  localparam int N_VI = 20;
  localparam int N_VO = 20;
  localparam int N_DO = 8;
  localparam int N_LED = 10;
  localparam int N_LAT = 18;
  localparam int N_STG = 16;
  localparam int N_OBJ_INH = 8;
  localparam int N_AR = 4;
  localparam int N_ROWS = 67;

  // matrix rows, one connection mask per destination
  localparam int ROW_DO = 0;
  localparam int ROW_LED = 8;
  localparam int ROW_DR = 18;
  localparam int ROW_VO = 19;
  localparam int ROW_BLK = 39;
  localparam int ROW_OBJ = 55;
  localparam int ROW_AR = 63;

  // source vector bit positions
  localparam int SRC_START = 0;
  localparam int SRC_TRIP = 16;
  localparam int SRC_DI = 32;
  localparam int SRC_FKEY = 48;
  localparam int SRC_OBJ_CMD = 50;
  localparam int SRC_LOGIC = 58;
  localparam int SRC_REL = 63;
  localparam int SRC_VI = 64;
  localparam int SRC_ALARM = 84;
  localparam int SRC_GOOSE = 88;

  // sources each matrix class may use
  localparam logic [95:0] ALLOW_OUT = 96'hffff_ffff_ffff_ffff_ffff_ffff;
  localparam logic [95:0] ALLOW_BLK = 96'h0000_0000_7c00_ffff_ffff_ffff;
  localparam logic [95:0] ALLOW_OBJ = 96'hffff_ffff_7c03_ffff_ffff_ffff;
  localparam logic [95:0] ALLOW_AR = 96'hffff_ffff_7c00_ffff_ffff_ffff;

  // register word addresses; rows sit at {row, word[1:0]} below 0x200
  localparam logic [9:0] A_SOFT_IN = 10'h200;
  localparam logic [9:0] A_SOFT_OUT = 10'h201;
  localparam logic [9:0] A_CTRL = 10'h202;
  localparam logic [9:0] A_LATCH_MODE = 10'h203;
  localparam logic [9:0] A_VI_EV_EN = 10'h204;
  localparam logic [9:0] A_VO_EV_EN = 10'h205;
  localparam logic [9:0] A_RELEASE = 10'h206;
  localparam logic [9:0] A_DEST_STAT = 10'h207;
  localparam logic [9:0] A_BLOCKED = 10'h208;
  localparam logic [9:0] A_CTL_STAT = 10'h209;

  // control register fields
  localparam int CTRL_FORCE = 0;
  localparam int CTRL_REL_SEL = 1;
  localparam int CTRL_REL_EN = 5;

  // reset values
  localparam logic [19:0] RST_BITS20 = 20'h00000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

/* File: verilog/vim_route_row.sv */
// vim_route_row: one matrix destination, OR of the sources its mask connects
// assumes: mask and sources are steady within a clock cycle
`timescale 1ns/10ps
module vim_route_row #(
  parameter logic [95:0] ALLOW = vim_pkg::ALLOW_OUT
) (
  input wire logic [vim_pkg::SRC_W-1:0] src_i,
  input wire logic [vim_pkg::SRC_W-1:0] mask_i,
  output logic hit_o
);

  // sources outside the class never reach the destination
  assign hit_o = |(src_i & mask_i & ALLOW);

endmodule // vim_route_row

/* File: verilog/vim_latch_cell.sv */
// vim_latch_cell: latched state of one output or indicator
// assumes: reset already synchronised, release is a one-cycle request
`timescale 1ns/10ps
module vim_latch_cell (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic release_i,
  output logic latched_o
);

  typedef struct packed {
    logic latched;
  } vim_cell_t;

  vim_cell_t st_r;
  vim_cell_t st_nxt;

  // set wins over release so an active source keeps the latch
  always_comb begin
    st_nxt = st_r;
    st_nxt.latched = (st_r.latched & ~release_i) | set_i;
  end

  // state register, cleared on reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign latched_o = st_r.latched;

endmodule // vim_latch_cell

/* File: verilog/vim_top.sv */
// vim_top: virtual inputs and outputs with output, blocking, object block and
// auto-recloser matrices of a protection relay
// assumes: all inputs synchronous to sys_clk_i; register port word-addressed
// Function
// - twenty memory-held soft inputs, readable, usable like digital inputs except in the blocking matrix
// - soft inputs writable from panel, communication bus and config port
// - soft input changes reach all consumers well within five milliseconds
// - twenty soft outputs from the matrix; direct writes only when forced
// - output matrix routes every source class to outputs, recorder, soft outputs
// - each digital output and indicator has its own latched mode bit
// - non-latched destination follows OR of its routed sources each cycle
// - latched destination sets on a source and holds until released
// - one common release clears all latched outputs and indicators
// - release from selected digital input, front panel or remote, equally
// - blocking matrix inhibits chosen stages while a blocking source is active
// - blocked flag only when blocking is active and stage is picking up
// - object block matrix inhibits open and close control per object
// - object command pulses never act as object inhibits
// - auto-recloser matrix routes sources to the recloser control inputs
// - release has effect only while some latched output is set
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
module vim_top (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [9:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  input wire logic [15:0] prot_start_i,
  input wire logic [15:0] prot_trip_i,
  input wire logic [15:0] stage_pickup_i,
  input wire logic [15:0] dig_in_i,
  input wire logic function_key_one_i,
  input wire logic function_key_two_i,
  input wire logic [7:0] obj_cmd_i,
  input wire logic [4:0] logic_out_i,
  input wire logic [3:0] alarm_i,
  input wire logic [7:0] goose_i,
  input wire logic [19:0] panel_vi_set_i,
  input wire logic [19:0] panel_vi_clr_i,
  input wire logic [19:0] comm_vi_set_i,
  input wire logic [19:0] comm_vi_clr_i,
  input wire logic panel_release_i,
  input wire logic comm_release_i,
  output logic [7:0] dig_out_o,
  output logic [9:0] led_o,
  output logic disturbance_recorder_trigger_o,
  output logic [19:0] soft_input_bits_o,
  output logic [19:0] soft_output_bits_o,
  output logic [15:0] stage_enable_o,
  output logic [15:0] stage_blocked_o,
  output logic [7:0] obj_inhibit_o,
  output logic [3:0] ar_ctl_o,
  output logic [19:0] soft_in_event_o,
  output logic [19:0] soft_out_event_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [vim_pkg::N_ROWS-1:0][vim_pkg::SRC_W-1:0] conn;
    logic [19:0] soft_in;
    logic [19:0] force_val;
    logic force_en;
    logic [3:0] rel_sel;
    logic rel_sel_en;
    logic [17:0] latch_mode;
    logic [19:0] vi_ev_en;
    logic [19:0] vo_ev_en;
    logic [7:0] do_q;
    logic [9:0] led_q;
    logic dr_q;
    logic [19:0] vo_q;
    logic [15:0] stg_en;
    logic [15:0] blocked;
    logic [7:0] obj_inh;
    logic [3:0] ar_ctl;
    logic [19:0] vi_ev;
    logic [19:0] vo_ev;
    logic rel_pulse;
    logic [31:0] rdata;
  } vim_state_t;

  vim_state_t st_r;
  vim_state_t st_nxt;
  logic rst_meta_r;
  logic rst_sync_r;
  logic [vim_pkg::SRC_W-1:0] src;
  logic [vim_pkg::N_ROWS-1:0] hit;
  logic [vim_pkg::N_LAT-1:0] latched;
  logic [vim_pkg::N_LAT-1:0] lat_set;
  logic rel_req;
  logic rel_eff;
  logic [7:0] row_idx;
  logic [1:0] word_idx;
  logic is_mtx;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release through two flops

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source vector; soft inputs sit between the release pulse and the alarms, but the blocking class mask leaves them out

  assign src = {goose_i,
                alarm_i,
                st_r.soft_in,
                st_r.rel_pulse,
                logic_out_i,
                obj_cmd_i,
                function_key_two_i,
                function_key_one_i,
                dig_in_i,
                prot_trip_i,
                prot_start_i};

  ////////////////////////////////////////////////////////////////////////////////
  // one routing row per destination, class mask chosen by row range

  genvar gr;
  generate
    for (gr = 0; gr < vim_pkg::N_ROWS; gr = gr + 1) begin : g_row
      localparam logic [95:0] ALLOW_ROW =
        (gr >= vim_pkg::ROW_AR) ? vim_pkg::ALLOW_AR :
        (gr >= vim_pkg::ROW_OBJ) ? vim_pkg::ALLOW_OBJ :
        (gr >= vim_pkg::ROW_BLK) ? vim_pkg::ALLOW_BLK : vim_pkg::ALLOW_OUT;
      vim_route_row #(
        .ALLOW(ALLOW_ROW)
      ) u_row (
        .src_i(src),
        .mask_i(st_r.conn[gr]),
        .hit_o(hit[gr])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // latch cells for digital outputs and indicators

  assign lat_set = hit[vim_pkg::N_LAT-1:0] & st_r.latch_mode;

  genvar gl;
  generate
    for (gl = 0; gl < vim_pkg::N_LAT; gl = gl + 1) begin : g_lat
      vim_latch_cell u_cell (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_sync_r),
        .ce_i(ce_i),
        .set_i(lat_set[gl]),
        .release_i(rel_eff),
        .latched_o(latched[gl])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // common latch release from any of four sources

  always_comb begin
    rel_req = panel_release_i | comm_release_i;
    if (st_r.rel_sel_en && dig_in_i[st_r.rel_sel]) begin
      rel_req = 1'b1;
    end
    if (wr_en_i && addr_i == vim_pkg::A_RELEASE && wr_data_i[0]) begin
      rel_req = 1'b1;
    end
  end

  // a release with nothing latched is dropped
  assign rel_eff = rel_req & (|latched);

  ////////////////////////////////////////////////////////////////////////////////
  // register port decode

  assign row_idx = addr_i[9:2];
  assign word_idx = addr_i[1:0];
  assign is_mtx = (addr_i[9] == 1'b0) && (row_idx < 8'(vim_pkg::N_ROWS)) &&
                  (word_idx != 2'h3);

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [19:0] vi_new;
    logic [19:0] vo_new;
    logic [15:0] blk_act;
    vi_new = st_r.soft_in;
    vo_new = st_r.vo_q;
    blk_act = 16'h0000;
    st_nxt = st_r;
    st_nxt.rdata = vim_pkg::RD_ZERO;

    // configuration writes
    if (wr_en_i) begin
      if (is_mtx) begin
        st_nxt.conn[row_idx][{word_idx, 5'h00} +: 32] = wr_data_i;
      end
      case (addr_i)
        vim_pkg::A_SOFT_IN: begin
          vi_new = wr_data_i[19:0];
        end
        vim_pkg::A_SOFT_OUT: begin
          if (st_r.force_en) begin
            st_nxt.force_val = wr_data_i[19:0];
          end
        end
        vim_pkg::A_CTRL: begin
          st_nxt.force_en = wr_data_i[vim_pkg::CTRL_FORCE];
          st_nxt.rel_sel = wr_data_i[vim_pkg::CTRL_REL_SEL +: 4];
          st_nxt.rel_sel_en = wr_data_i[vim_pkg::CTRL_REL_EN];
        end
        vim_pkg::A_LATCH_MODE: begin
          st_nxt.latch_mode = wr_data_i[17:0];
        end
        vim_pkg::A_VI_EV_EN: begin
          st_nxt.vi_ev_en = wr_data_i[19:0];
        end
        vim_pkg::A_VO_EV_EN: begin
          st_nxt.vo_ev_en = wr_data_i[19:0];
        end
        default: begin
        end
      endcase
    end

    // panel then communication set and clear of soft inputs
    vi_new = (vi_new | panel_vi_set_i) & ~panel_vi_clr_i;
    vi_new = (vi_new | comm_vi_set_i) & ~comm_vi_clr_i;
    st_nxt.soft_in = vi_new;
    st_nxt.vi_ev = (vi_new ^ st_r.soft_in) & st_r.vi_ev_en;

    // output matrix: non-latched follows the OR, latched adds the held state
    st_nxt.do_q = hit[vim_pkg::ROW_DO +: 8] |
                  (latched[7:0] & st_r.latch_mode[7:0]);
    st_nxt.led_q = hit[vim_pkg::ROW_LED +: 10] |
                   (latched[17:8] & st_r.latch_mode[17:8]);
    st_nxt.dr_q = hit[vim_pkg::ROW_DR];

    // soft outputs come from the matrix unless the force flag holds them
    if (st_r.force_en) begin
      vo_new = st_r.force_val;
    end else begin
      vo_new = hit[vim_pkg::ROW_VO +: 20];
    end
    st_nxt.vo_q = vo_new;
    st_nxt.vo_ev = (vo_new ^ st_r.vo_q) & st_r.vo_ev_en;

    // blocking: stage inhibited while source active, flag only on pickup
    blk_act = hit[vim_pkg::ROW_BLK +: 16];
    st_nxt.stg_en = ~blk_act;
    st_nxt.blocked = blk_act & stage_pickup_i;

    // object inhibits and recloser controls
    st_nxt.obj_inh = hit[vim_pkg::ROW_OBJ +: 8];
    st_nxt.ar_ctl = hit[vim_pkg::ROW_AR +: 4];

    // release seen by the matrix as a one-cycle source
    st_nxt.rel_pulse = rel_eff;

    // read data for the next cycle
    if (rd_en_i) begin
      if (is_mtx) begin
        st_nxt.rdata = st_r.conn[row_idx][{word_idx, 5'h00} +: 32];
      end else begin
        case (addr_i)
          vim_pkg::A_SOFT_IN: begin
            st_nxt.rdata = {12'h000, st_r.soft_in};
          end
          vim_pkg::A_SOFT_OUT: begin
            st_nxt.rdata = {12'h000, st_r.vo_q};
          end
          vim_pkg::A_CTRL: begin
            st_nxt.rdata = {26'h0000000, st_r.rel_sel_en, st_r.rel_sel, st_r.force_en};
          end
          vim_pkg::A_LATCH_MODE: begin
            st_nxt.rdata = {14'h0000, st_r.latch_mode};
          end
          vim_pkg::A_VI_EV_EN: begin
            st_nxt.rdata = {12'h000, st_r.vi_ev_en};
          end
          vim_pkg::A_VO_EV_EN: begin
            st_nxt.rdata = {12'h000, st_r.vo_ev_en};
          end
          vim_pkg::A_DEST_STAT: begin
            // only the low twelve latch states fit beside the live outputs
            st_nxt.rdata = {latched[11:8], latched[7:0], 1'b0, st_r.dr_q,
                            st_r.led_q, st_r.do_q};
          end
          vim_pkg::A_BLOCKED: begin
            st_nxt.rdata = {st_r.stg_en, st_r.blocked};
          end
          vim_pkg::A_CTL_STAT: begin
            st_nxt.rdata = {20'h00000, st_r.ar_ctl, st_r.obj_inh};
          end
          default: begin
            st_nxt.rdata = vim_pkg::RD_ZERO;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; everything clears on reset, ce low freezes it

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign rd_data_o = st_r.rdata;
  assign dig_out_o = st_r.do_q;
  assign led_o = st_r.led_q;
  assign disturbance_recorder_trigger_o = st_r.dr_q;
  assign soft_input_bits_o = st_r.soft_in;
  assign soft_output_bits_o = st_r.vo_q;
  assign stage_enable_o = st_r.stg_en;
  assign stage_blocked_o = st_r.blocked;
  assign obj_inhibit_o = st_r.obj_inh;
  assign ar_ctl_o = st_r.ar_ctl;
  assign soft_in_event_o = st_r.vi_ev;
  assign soft_out_event_o = st_r.vo_ev;

endmodule // vim_top

/* File: tb/vim_top_checker.sv */
// vim_top_checker: port-level properties of the signal matrix
// assumes: bound to vim_top, one clock domain
`timescale 1ns/10ps
module vim_top_checker (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [9:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [15:0] stage_pickup_i,
  input wire logic [19:0] panel_vi_set_i,
  input wire logic [19:0] panel_vi_clr_i,
  input wire logic [19:0] comm_vi_set_i,
  input wire logic [19:0] comm_vi_clr_i,
  input wire logic [7:0] dig_out_o,
  input wire logic [9:0] led_o,
  input wire logic [19:0] soft_input_bits_o,
  input wire logic [19:0] soft_output_bits_o,
  input wire logic [15:0] stage_enable_o,
  input wire logic [15:0] stage_blocked_o,
  input wire logic [19:0] soft_in_event_o,
  input wire logic [19:0] soft_out_event_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // register port answers
  AST_RD_IDLE: assert property (ce_i && !rd_en_i |=> rd_data_o == 32'h0)
    else $error("read data not idle");
  AST_RD_SOFT_IN: assert property (ce_i && rd_en_i && addr_i == vim_pkg::A_SOFT_IN
    |=> rd_data_o == {12'h0, $past(soft_input_bits_o)}) else $error("soft input readback");
  AST_RD_SOFT_OUT: assert property (ce_i && rd_en_i && addr_i == vim_pkg::A_SOFT_OUT
    |=> rd_data_o == {12'h0, $past(soft_output_bits_o)}) else $error("soft output readback");
  AST_SOFT_IN_WR: assert property (ce_i && wr_en_i && addr_i == vim_pkg::A_SOFT_IN
    && ~|{panel_vi_set_i, panel_vi_clr_i, comm_vi_set_i, comm_vi_clr_i}
    |=> soft_input_bits_o == $past(wr_data_i[19:0])) else $error("soft input write lost");
  ////////////////////////////////////////////////////////////////////////////
  // blocking flags, event pulses and outputs held clear in reset
  AST_BLK_EXCL: assert property ((stage_blocked_o & stage_enable_o) == 16'h0)
    else $error("stage blocked yet enabled");
  AST_BLK_PICK: assert property (ce_i |=> (stage_blocked_o & ~$past(stage_pickup_i)) == 16'h0)
    else $error("blocked flag without pickup");
  AST_VI_EVENT: assert property ($past(ce_i) |->
    (soft_in_event_o & ~(soft_input_bits_o ^ $past(soft_input_bits_o))) == 20'h0)
    else $error("soft input event without change");
  AST_VO_EVENT: assert property ($past(ce_i) |->
    (soft_out_event_o & ~(soft_output_bits_o ^ $past(soft_output_bits_o))) == 20'h0)
    else $error("soft output event without change");
  AST_RST_CLEAR: assert property (disable iff (1'b0) !reset_n_i |-> dig_out_o == 8'h0
    && led_o == 10'h0 && soft_output_bits_o == 20'h0 && stage_enable_o == 16'h0)
    else $error("output active in reset");
endmodule // vim_top_checker

/* File: tb/vim_src_model.sv */
// vim_src_model: relay-side sources (stages, inputs, keys, logic, alarms, goose)
// assumes: bench gives the source pattern in source vector bit order
`timescale 1ns/10ps
module vim_src_model (
  input wire logic sys_clk_i,
  input wire logic [95:0] pat_i,
  input wire logic [15:0] pick_i,
  output logic [15:0] start_o,
  output logic [15:0] trip_o,
  output logic [15:0] pickup_o,
  output logic [15:0] di_o,
  output logic key1_o,
  output logic key2_o,
  output logic [7:0] obj_cmd_o,
  output logic [4:0] logic_o,
  output logic [3:0] alarm_o,
  output logic [7:0] goose_o
);
  // sources move just after the edge, like real stage and contact outputs
  always_ff @(posedge sys_clk_i) begin
    start_o <= pat_i[15:0];
    trip_o <= pat_i[31:16];
    di_o <= pat_i[47:32];
    key1_o <= pat_i[48];
    key2_o <= pat_i[49];
    obj_cmd_o <= pat_i[57:50];
    logic_o <= pat_i[62:58];
    alarm_o <= pat_i[87:84];
    goose_o <= pat_i[95:88];
    pickup_o <= pick_i;
  end
endmodule // vim_src_model

/* File: tb/tb_top.sv */
// tb_top: self-checking bench of the signal matrix
// assumes: 20 MHz clock, source model registers the bench pattern
`timescale 1ns/10ps
module tb_top;
  logic sys_clk_i, reset_n_i, ce_i, wr_en_i, rd_en_i, panel_release_i, comm_release_i;
  logic [9:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o, d;
  logic [95:0] pat;
  logic [15:0] pick, st, tr, pu, di, se, sb, m;
  logic k1, k2, dr;
  logic [7:0] oc, go, dig_out_o, oi;
  logic [4:0] lo;
  logic [3:0] al, ar;
  logic [9:0] led_o;
  logic [19:0] pvs, pvc, cvs, cvc, sin, sout, sie, soe, vi;
  logic [38:0] dest;
  int n_mismatch, samples_checked, vi_ev, vo_ev, exp_ev, n0;
  assign dest = {sout, dr, led_o, dig_out_o};
  ////////////////////////////////////////////////////////////////////////////
  // design, source model, clock and event counters
  vim_top dut (.sys_clk_i, .reset_n_i, .ce_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
    .rd_data_o, .prot_start_i(st), .prot_trip_i(tr), .stage_pickup_i(pu), .dig_in_i(di),
    .function_key_one_i(k1), .function_key_two_i(k2), .obj_cmd_i(oc), .logic_out_i(lo),
    .alarm_i(al), .goose_i(go), .panel_vi_set_i(pvs), .panel_vi_clr_i(pvc),
    .comm_vi_set_i(cvs), .comm_vi_clr_i(cvc), .panel_release_i, .comm_release_i,
    .dig_out_o, .led_o, .disturbance_recorder_trigger_o(dr), .soft_input_bits_o(sin),
    .soft_output_bits_o(sout), .stage_enable_o(se), .stage_blocked_o(sb),
    .obj_inhibit_o(oi), .ar_ctl_o(ar), .soft_in_event_o(sie), .soft_out_event_o(soe));
  vim_src_model u_src (.sys_clk_i, .pat_i(pat), .pick_i(pick), .start_o(st), .trip_o(tr),
    .pickup_o(pu), .di_o(di), .key1_o(k1), .key2_o(k2), .obj_cmd_o(oc), .logic_o(lo),
    .alarm_o(al), .goose_o(go));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    vi_ev <= vi_ev + $countones(sie);
    vo_ev <= vo_ev + $countones(soe);
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus cycles, pulses and comparison
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic wr(input int a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= 10'(a);
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input int a, output logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= 10'(a);
    rd_en_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    @(negedge sys_clk_i);
    v = rd_data_o;
  endtask
  task automatic poke(input int sel, input logic [19:0] v);
    @(posedge sys_clk_i);
    case (sel)
      0: pvs <= v;
      1: pvc <= v;
      2: cvs <= v;
      3: cvc <= v;
      4: panel_release_i <= v[0];
      default: comm_release_i <= v[0];
    endcase
    @(posedge sys_clk_i);
    {pvs, pvc, cvs, cvc, panel_release_i, comm_release_i} <= '0;
  endtask
  // sel 0..3 panel/comm set/clear, 4 register write
  task automatic vi_step(input int sel, input logic [19:0] v);
    logic [19:0] nv;
    nv = (sel == 4) ? v : (sel[0] ? vi & ~v : vi | v);
    if (sel == 4) wr(vim_pkg::A_SOFT_IN, {12'h0, v});
    else poke(sel, v);
    settle();
    exp_ev += $countones(vi ^ nv);
    vi = nv;
    chk(sin, vi);
  endtask
  task automatic drive(input int b, input logic on);
    if (b >= 64 && b < 84) vi_step(4, on ? vi | (20'h1 << (b - 64)) : vi & ~(20'h1 << (b - 64)));
    else begin
      @(posedge sys_clk_i);
      pat[b] <= on;
      settle();
    end
  endtask
  task automatic rst_check;
    chk(dest, 39'h0);
    rd(4 * 0 + 1, d);
    chk(d, 32'h0);
    rd(vim_pkg::A_LATCH_MODE, d);
    chk(d, 32'h0);
    rd(10'h3ff, d);
    chk(d, 32'h0);
    $display("reset test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog over the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int rows[10];
    int bits[10];
    rows = '{1, 9, 18, 19, 20, 11, 2, 21, 3, 22};
    bits = '{32, 48, 0, 88, 58, 84, 16, 50, 64, 49};
    {wr_en_i, rd_en_i, panel_release_i, comm_release_i} = '0;
    reset_n_i = 1'b1;
    {addr_i, wr_data_i, pat, pick, pvs, pvc, cvs, cvc, vi} = '0;
    {vi_ev, vo_ev, exp_ev, n_mismatch, samples_checked} = '0;
    ce_i = 1'b1;
    // a clean falling edge so the asynchronous reset is always seen
    #1 reset_n_i = 1'b0;
    void'($urandom(32'hda636d3f));
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    settle();
    rst_check();
    // soft inputs from every writer, with events on then off
    wr(vim_pkg::A_VI_EV_EN, 32'hfffff);
    n0 = vi_ev;
    vi_step(4, 20'($urandom));
    rd(vim_pkg::A_SOFT_IN, d);
    chk(d, {12'h0, vi});
    for (int s = 0; s < 4; s++) vi_step(s, 20'h1 << s);
    chk(vi_ev - n0, exp_ev);
    wr(vim_pkg::A_VI_EV_EN, 32'h0);
    n0 = vi_ev;
    vi_step(4, 20'h0);
    chk(vi_ev - n0, 0);
    $display("soft input test done");
    // every source class but the release pulse to each output matrix destination kind
    for (int i = 0; i < 10; i++) begin
      wr(rows[i] * 4 + bits[i] / 32, 32'h1 << (bits[i] % 32));
      drive(bits[i], 1'b1);
      chk(dest[rows[i]], 1'b1);
      drive(bits[i], 1'b0);
      chk(dest[rows[i]], 1'b0);
      wr(rows[i] * 4 + bits[i] / 32, 32'h0);
    end
    m = 16'($urandom);
    wr(1, {16'h0, m});
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i);
      pat[47:32] <= 16'($urandom);
      settle();
      chk(dig_out_o[0], |(m & di));
    end
    wr(1, 32'h0);
    @(posedge sys_clk_i);
    pat <= '0;
    $display("routing test done");
    // soft output writes only under force
    wr(vim_pkg::A_SOFT_OUT, 32'h5a5a5);
    settle();
    chk(sout, 20'h0);
    wr(vim_pkg::A_CTRL, 32'h1);
    wr(vim_pkg::A_SOFT_OUT, 32'ha5a5a);
    settle();
    chk(sout, 20'ha5a5a);
    wr(vim_pkg::A_CTRL, 32'h0);
    $display("force test done");
    // blocking, object inhibits and recloser
    wr(39 * 4 + 1, 32'h1);
    wr(41 * 4 + 2, 32'h1 << 24);
    wr(55 * 4 + 1, 32'h40001);
    wr(63 * 4 + 2, 32'h1 << 24);
    wr(64 * 4 + 1, 32'h1 << 16);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      pat[32] <= i[0];
      pick <= {16{i[1]}};
      settle();
      chk(se[0], !i[0]);
      chk(sb[0], i[0] & i[1]);
    end
    drive(32, 1'b0);
    drive(50, 1'b1);
    chk(oi[0], 1'b0);
    drive(32, 1'b1);
    chk(oi[0], 1'b1);
    drive(88, 1'b1);
    drive(48, 1'b1);
    chk(ar[1:0], 2'b01);
    chk(se[2], 1'b1);
    @(posedge sys_clk_i);
    pat <= '0;
    $display("blocking test done");
    // latches, release from each source, idle release does nothing
    wr(19 * 4 + 1, 32'h8000_0000);
    wr(vim_pkg::A_VO_EV_EN, 32'h1);
    n0 = vo_ev;
    wr(vim_pkg::A_RELEASE, 32'h1);
    settle();
    chk(vo_ev - n0, 0);
    wr(vim_pkg::A_LATCH_MODE, 32'h101);
    for (int r = 0; r < 3; r++) wr((r == 2 ? 8 : r) * 4 + 1, 32'h2);
    for (int k = 0; k < 4; k++) begin
      drive(33, 1'b1);
      drive(33, 1'b0);
      chk({dest[8], dest[1], dest[0]}, 3'b101);
      rd(vim_pkg::A_DEST_STAT, d);
      chk(d, 32'h1010_0101);
      if (k == 0) wr(vim_pkg::A_RELEASE, 32'h1);
      else if (k < 3) poke(k + 3, 20'h1);
      else begin
        wr(vim_pkg::A_CTRL, 32'h24);
        drive(34, 1'b1);
        drive(34, 1'b0);
        wr(vim_pkg::A_CTRL, 32'h0);
      end
      settle();
      chk({dest[8], dest[0]}, 2'b00);
    end
    $display("latch test done");
    // second reset clears configuration and latches
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    settle();
    rst_check();
    test_done();
  end
endmodule // tb_top
bind vim_top vim_top_checker u_chk (.sys_clk_i, .reset_n_i, .ce_i, .addr_i, .wr_data_i,
  .wr_en_i, .rd_en_i, .rd_data_o, .stage_pickup_i, .panel_vi_set_i, .panel_vi_clr_i,
  .comm_vi_set_i, .comm_vi_clr_i, .dig_out_o, .led_o, .soft_input_bits_o,
  .soft_output_bits_o, .stage_enable_o, .stage_blocked_o, .soft_in_event_o,
  .soft_out_event_o);
